//--- rtl/multifunction_timer.sv
// Two independent 16-bit multifunction timers with PWM, capture and compare
// What this block does
// - Two identical timers, each with two capture pins, clock pin, one output.
// - 16-bit up-counter advanced via 15-bit prescaler, system or synced ext clock.
// - Counter never written directly; counter_clear_bit write clears it to zero.
// - Pin direction overrides timer; software sets pin directions to match.
// - PWM period from period_capture_reg_2, high time from compare_reg_1.
// - PWM: counter at compare minus one drops output next edge, count continues.
// - PWM: counter at period minus one clears; output high, or low if compare zero.
// - Compare zero holds output low; compare equal period holds it high.
// - New PWM compare and period take effect only when the counter resets.
// - PWM interrupts on output set and clear; 0%/100% interrupt on every reset.
// - PWM: enabled capture input 1 copies counter into capture_reg_1.
// - Timer mode is PWM mode with output_enable cleared.
// - Capture inputs enabled in config 1; edge rise, fall or both in config 2.
// - Capture trigger copies counter into capture_reg_1 or period_capture_reg_2.
// - Reset-on-capture-1 stores pre-reset count, then zeroes counter; may interrupt.
// - tie_capture_inputs drives capture input 2 internally from capture input 1.
// - Capture mode interrupts for each capture event and overflow, each enabled.
// - Capture mode: counter at compare minus one toggles output next count.
// - With output_enable, force_output_high/low writes drive output high/low.
// - Overflow flag sets when counter wraps from maximum to zero.
// - Low compare byte write only stores; high byte write loads 16-bit value.
// - 4-bit prescale_select divides by two to the power of its value.
// - Low counter byte read returns low bits and latches high byte.
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps

module multifunction_timer
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [5:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [1:0] capture_in_1_i,
  input wire logic [1:0] capture_in_2_i,
  input wire logic [1:0] ext_event_clock_i,
  output logic [7:0] rdata_o,
  output logic [1:0] timer_output_o,
  output logic [1:0] timer_output_oe_o,
  output logic [1:0] irq_o
);

  // ******************************************************************
  // Helpers
  // ******************************************************************
  // Register decode within one timer's window
  function automatic logic reg_hit(input logic [5:0] a, input int t,
                                   input logic [3:0] r);
    return (a[mft_pkg::SHARED_SEL_BIT] == 1'b0) &&
           (a[mft_pkg::TIMER_SEL_BIT] == t[0]) && (a[3:0] == r);
  endfunction

  // Edge match against a two-bit rise/fall select
  function automatic logic edge_hit(input logic cur, input logic prev,
                                    input logic [1:0] sel);
    return (sel[mft_pkg::EDGE_RISE_BIT] && cur && !prev) ||
           (sel[mft_pkg::EDGE_FALL_BIT] && !cur && prev);
  endfunction

  // Prescaler terminal count for divisor two to the power of sel
  function automatic logic pre_hit(input logic [14:0] ps, input logic [3:0] sel);
    logic [14:0] m;
    m = ~(mft_pkg::PS_ONES << sel);
    return (ps & m) == m;
  endfunction

  // ******************************************************************
  // State
  // ******************************************************************
  mft_pkg::cfg1_ctl_t ctl_r [mft_pkg::NUM_TIMERS];
  logic [7:0] flags_r [mft_pkg::NUM_TIMERS];
  logic [7:0] cfg2_r [mft_pkg::NUM_TIMERS];
  logic [1:0] tie_r;
  logic [15:0] cmp_wr_r [mft_pkg::NUM_TIMERS];
  logic [15:0] cmp_ld_r [mft_pkg::NUM_TIMERS];
  logic [15:0] cmp_act_r [mft_pkg::NUM_TIMERS];
  logic [15:0] per_wr_r [mft_pkg::NUM_TIMERS];
  logic [15:0] per_ld_r [mft_pkg::NUM_TIMERS];
  logic [15:0] per_act_r [mft_pkg::NUM_TIMERS];
  logic [15:0] cnt_r [mft_pkg::NUM_TIMERS];
  logic [15:0] cap1_r [mft_pkg::NUM_TIMERS];
  logic [15:0] cap2_r [mft_pkg::NUM_TIMERS];
  logic [7:0] cnt_hl_r [mft_pkg::NUM_TIMERS];
  logic [7:0] cap1_hl_r [mft_pkg::NUM_TIMERS];
  logic [7:0] cap2_hl_r [mft_pkg::NUM_TIMERS];
  logic [14:0] ps_r [mft_pkg::NUM_TIMERS];
  logic [5:0] pin_s1_r;
  logic [5:0] pin_s2_r;
  logic [5:0] pin_d_r;
  logic [1:0] out_r;
  logic [1:0] irq_r;
  logic [7:0] rdata_r;

  logic [1:0] tick;
  logic [1:0] cap1_ev;
  logic [1:0] cap2_ev;
  logic [1:0] clr_wr;
  logic [1:0] zero_ev;
  logic [1:0] pwm_wrap;
  logic [1:0] pwm_fall;
  logic [1:0] cmp_hit;
  logic [1:0] ovf_ev;
  logic [1:0] force_hi;
  logic [1:0] force_lo;
  logic [7:0] rdata_nxt;

  // ******************************************************************
  // Pin synchronisers
  // ******************************************************************
  // Two stages ahead of any logic; third stage only keeps history for edges
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pin_s1_r <= 6'h00;
      pin_s2_r <= 6'h00;
      pin_d_r <= 6'h00;
    end
    else if (ce_i)
    begin
      for (int i = 0; i < mft_pkg::NUM_TIMERS; i++)
      begin
        pin_s1_r[i*3+mft_pkg::PIN_CAP1] <= capture_in_1_i[i];
        pin_s1_r[i*3+mft_pkg::PIN_CAP2] <= capture_in_2_i[i];
        pin_s1_r[i*3+mft_pkg::PIN_ECLK] <= ext_event_clock_i[i];
      end
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
    end
  end

  // ******************************************************************
  // Event decode
  // ******************************************************************
  // All per-timer strobes for this cycle; clear and wrap priority is resolved here, forcing in the output block
  always_comb
  begin
    for (int i = 0; i < mft_pkg::NUM_TIMERS; i++)
    begin
      logic src;
      logic c1;
      logic c1d;
      logic c2;
      logic c2d;
      logic ek;
      logic ekd;
      logic busy;
      c1 = pin_s2_r[i*3+mft_pkg::PIN_CAP1];
      c1d = pin_d_r[i*3+mft_pkg::PIN_CAP1];
      c2 = tie_r[i] ? c1 : pin_s2_r[i*3+mft_pkg::PIN_CAP2];
      c2d = tie_r[i] ? c1d : pin_d_r[i*3+mft_pkg::PIN_CAP2];
      ek = pin_s2_r[i*3+mft_pkg::PIN_ECLK];
      ekd = pin_d_r[i*3+mft_pkg::PIN_ECLK];
      // External clock edge selected by ext_clk_fall
      src = ctl_r[i].ext_clk_en ?
            edge_hit(ek, ekd, ctl_r[i].ext_clk_fall ? 2'b10 : 2'b01) : 1'b1;
      tick[i] = ctl_r[i].timer_en && src &&
                pre_hit(ps_r[i], cfg2_r[i][mft_pkg::PS_LSB +: 4]);
      cap1_ev[i] = ctl_r[i].cap1_en &&
                   edge_hit(c1, c1d, cfg2_r[i][mft_pkg::EDGE1_LSB +: 2]);
      cap2_ev[i] = ctl_r[i].capture_mode && ctl_r[i].cap2_en &&
                   edge_hit(c2, c2d, cfg2_r[i][mft_pkg::EDGE2_LSB +: 2]);
      clr_wr[i] = wr_i && (addr_i == mft_pkg::ADDR_CTRL) && wdata_i[i];
      busy = clr_wr[i] || (cap1_ev[i] && ctl_r[i].reset_on_cap1);
      pwm_wrap[i] = !busy && tick[i] && !ctl_r[i].capture_mode &&
                    (cnt_r[i] == per_act_r[i] - mft_pkg::CNT_ONE);
      pwm_fall[i] = !busy && tick[i] && !ctl_r[i].capture_mode && !pwm_wrap[i] &&
                    (cmp_act_r[i] != mft_pkg::WORD_RESET) &&
                    (cnt_r[i] == cmp_act_r[i] - mft_pkg::CNT_ONE);
      cmp_hit[i] = !busy && tick[i] && ctl_r[i].capture_mode &&
                   (cnt_r[i] == cmp_ld_r[i] - mft_pkg::CNT_ONE);
      ovf_ev[i] = !busy && tick[i] && (cnt_r[i] == mft_pkg::CNT_MAX);
      zero_ev[i] = busy || pwm_wrap[i];
      force_hi[i] = wr_i && reg_hit(addr_i, i, mft_pkg::REG_CFG2_HI) &&
                    wdata_i[mft_pkg::FORCE_HIGH_BIT] && ctl_r[i].output_enable;
      force_lo[i] = wr_i && reg_hit(addr_i, i, mft_pkg::REG_CFG2_HI) &&
                    wdata_i[mft_pkg::FORCE_LOW_BIT] && ctl_r[i].output_enable;
    end
  end

  // ******************************************************************
  // Configuration and compare/period write path
  // ******************************************************************
  // Low bytes are parked; the high byte write loads the 16-bit value
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      tie_r <= 2'b00;
      for (int i = 0; i < mft_pkg::NUM_TIMERS; i++)
      begin
        ctl_r[i] <= mft_pkg::cfg1_ctl_t'(mft_pkg::BYTE_RESET);
        cfg2_r[i] <= mft_pkg::BYTE_RESET;
        cmp_wr_r[i] <= mft_pkg::WORD_RESET;
        cmp_ld_r[i] <= mft_pkg::WORD_RESET;
        per_wr_r[i] <= mft_pkg::WORD_RESET;
        per_ld_r[i] <= mft_pkg::WORD_RESET;
      end
    end
    else if (ce_i && wr_i)
    begin
      for (int i = 0; i < mft_pkg::NUM_TIMERS; i++)
      begin
        if (reg_hit(addr_i, i, mft_pkg::REG_CFG1_HI))
          ctl_r[i] <= mft_pkg::cfg1_ctl_t'(wdata_i);
        if (reg_hit(addr_i, i, mft_pkg::REG_CFG2_LO))
          cfg2_r[i] <= wdata_i;
        if (reg_hit(addr_i, i, mft_pkg::REG_CFG2_HI))
          tie_r[i] <= wdata_i[mft_pkg::TIE_BIT];
        if (reg_hit(addr_i, i, mft_pkg::REG_CMP1_LO))
          cmp_wr_r[i][7:0] <= wdata_i;
        if (reg_hit(addr_i, i, mft_pkg::REG_CMP1_HI))
        begin
          cmp_wr_r[i][15:8] <= wdata_i;
          cmp_ld_r[i] <= {wdata_i, cmp_wr_r[i][7:0]};
        end
        // Period is read-only while capturing
        if (reg_hit(addr_i, i, mft_pkg::REG_PER_LO) && !ctl_r[i].capture_mode)
          per_wr_r[i][7:0] <= wdata_i;
        if (reg_hit(addr_i, i, mft_pkg::REG_PER_HI) && !ctl_r[i].capture_mode)
        begin
          per_wr_r[i][15:8] <= wdata_i;
          per_ld_r[i] <= {wdata_i, per_wr_r[i][7:0]};
        end
      end
    end
  end

  // ******************************************************************
  // Prescaler
  // ******************************************************************
  // Held at zero while the timer is off so a restart is deterministic
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      for (int i = 0; i < mft_pkg::NUM_TIMERS; i++)
        ps_r[i] <= mft_pkg::PS_RESET;
    end
    else if (ce_i)
    begin
      for (int i = 0; i < mft_pkg::NUM_TIMERS; i++)
      begin
        if (!ctl_r[i].timer_en)
          ps_r[i] <= mft_pkg::PS_RESET;
        else if (!ctl_r[i].ext_clk_en ||
                 edge_hit(pin_s2_r[i*3+mft_pkg::PIN_ECLK], pin_d_r[i*3+mft_pkg::PIN_ECLK],
                          ctl_r[i].ext_clk_fall ? 2'b10 : 2'b01))
          ps_r[i] <= ps_r[i] + 15'h0001;
      end
    end
  end

  // ******************************************************************
  // Counter, active PWM values and captures
  // ******************************************************************
  // Shadows move to active only at a counter reset, so no mid-cycle glitch
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      for (int i = 0; i < mft_pkg::NUM_TIMERS; i++)
      begin
        cnt_r[i] <= mft_pkg::WORD_RESET;
        cmp_act_r[i] <= mft_pkg::WORD_RESET;
        per_act_r[i] <= mft_pkg::WORD_RESET;
        cap1_r[i] <= mft_pkg::WORD_RESET;
        cap2_r[i] <= mft_pkg::WORD_RESET;
      end
    end
    else if (ce_i)
    begin
      for (int i = 0; i < mft_pkg::NUM_TIMERS; i++)
      begin
        if (zero_ev[i])
          cnt_r[i] <= mft_pkg::WORD_RESET;
        else if (tick[i])
          cnt_r[i] <= cnt_r[i] + mft_pkg::CNT_ONE;
        if (zero_ev[i])
        begin
          cmp_act_r[i] <= cmp_ld_r[i];
          per_act_r[i] <= per_ld_r[i];
        end
        if (cap1_ev[i])
          cap1_r[i] <= cnt_r[i];
        if (cap2_ev[i])
          cap2_r[i] <= cnt_r[i];
      end
    end
  end

  // ******************************************************************
  // Timer output
  // ******************************************************************
  // Software forcing beats the waveform in the same cycle
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      out_r <= 2'b00;
    else if (ce_i)
    begin
      for (int i = 0; i < mft_pkg::NUM_TIMERS; i++)
      begin
        if (force_hi[i])
          out_r[i] <= 1'b1;
        else if (force_lo[i])
          out_r[i] <= 1'b0;
        else if (!ctl_r[i].capture_mode && zero_ev[i])
          out_r[i] <= (cmp_ld_r[i] != mft_pkg::WORD_RESET);
        else if (pwm_fall[i])
          out_r[i] <= 1'b0;
        else if (cmp_hit[i])
          out_r[i] <= ~out_r[i];
      end
    end
  end

  // ******************************************************************
  // Interrupt flags and enables
  // ******************************************************************
  // Writing a zero clears a flag, but a same-cycle event keeps it set
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      irq_r <= 2'b00;
      for (int i = 0; i < mft_pkg::NUM_TIMERS; i++)
        flags_r[i] <= mft_pkg::BYTE_RESET;
    end
    else if (ce_i)
    begin
      for (int i = 0; i < mft_pkg::NUM_TIMERS; i++)
      begin
        logic [3:0] set;
        logic [7:0] cur;
        logic pwm_edge;
        // Every PWM reset is an output-set event, or the 0%/100% reset tick
        pwm_edge = !ctl_r[i].capture_mode && zero_ev[i];
        set = 4'h0;
        set[mft_pkg::FLAG_CMP1] = pwm_edge || cmp_hit[i];
        set[mft_pkg::FLAG_CAP1] = cap1_ev[i];
        set[mft_pkg::FLAG_CAP2] = cap2_ev[i] || pwm_fall[i];
        set[mft_pkg::FLAG_OVF] = ovf_ev[i];
        cur = flags_r[i];
        if (wr_i && reg_hit(addr_i, i, mft_pkg::REG_CFG1_LO))
          cur = {wdata_i[7:4], cur[3:0] & wdata_i[3:0]};
        flags_r[i] <= {cur[7:4], cur[3:0] | set};
        irq_r[i] <= |(flags_r[i][3:0] & flags_r[i][7:mft_pkg::IE_LSB]);
      end
    end
  end

  // ******************************************************************
  // Read path
  // ******************************************************************
  // Unmapped and write-only locations read zero
  always_comb
  begin
    rdata_nxt = mft_pkg::BYTE_RESET;
    for (int i = 0; i < mft_pkg::NUM_TIMERS; i++)
    begin
      if (reg_hit(addr_i, i, mft_pkg::REG_CNT_LO))
        rdata_nxt = cnt_r[i][7:0];
      if (reg_hit(addr_i, i, mft_pkg::REG_CNT_HI))
        rdata_nxt = cnt_hl_r[i];
      if (reg_hit(addr_i, i, mft_pkg::REG_CAP1_LO))
        rdata_nxt = cap1_r[i][7:0];
      if (reg_hit(addr_i, i, mft_pkg::REG_CAP1_HI))
        rdata_nxt = cap1_hl_r[i];
      if (reg_hit(addr_i, i, mft_pkg::REG_CMP1_LO))
        rdata_nxt = cmp_wr_r[i][7:0];
      if (reg_hit(addr_i, i, mft_pkg::REG_CMP1_HI))
        rdata_nxt = cmp_wr_r[i][15:8];
      if (reg_hit(addr_i, i, mft_pkg::REG_PER_LO))
        rdata_nxt = ctl_r[i].capture_mode ? cap2_r[i][7:0] : per_wr_r[i][7:0];
      if (reg_hit(addr_i, i, mft_pkg::REG_PER_HI))
        rdata_nxt = ctl_r[i].capture_mode ? cap2_hl_r[i] : per_wr_r[i][15:8];
      if (reg_hit(addr_i, i, mft_pkg::REG_CFG1_LO))
        rdata_nxt = flags_r[i];
      if (reg_hit(addr_i, i, mft_pkg::REG_CFG1_HI))
        rdata_nxt = ctl_r[i];
      if (reg_hit(addr_i, i, mft_pkg::REG_CFG2_LO))
        rdata_nxt = cfg2_r[i];
      if (reg_hit(addr_i, i, mft_pkg::REG_CFG2_HI))
        rdata_nxt = {5'h00, tie_r[i], 2'b00}; // Force bits always read zero
    end
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      rdata_r <= mft_pkg::BYTE_RESET;
    else if (ce_i)
      rdata_r <= rd_i ? rdata_nxt : mft_pkg::BYTE_RESET;
  end

  // High-byte latches so a later high read pairs with the low read
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      for (int i = 0; i < mft_pkg::NUM_TIMERS; i++)
      begin
        cnt_hl_r[i] <= mft_pkg::BYTE_RESET;
        cap1_hl_r[i] <= mft_pkg::BYTE_RESET;
        cap2_hl_r[i] <= mft_pkg::BYTE_RESET;
      end
    end
    else if (ce_i && rd_i)
    begin
      for (int i = 0; i < mft_pkg::NUM_TIMERS; i++)
      begin
        if (reg_hit(addr_i, i, mft_pkg::REG_CNT_LO))
          cnt_hl_r[i] <= cnt_r[i][15:8];
        if (reg_hit(addr_i, i, mft_pkg::REG_CAP1_LO))
          cap1_hl_r[i] <= cap1_r[i][15:8];
        if (reg_hit(addr_i, i, mft_pkg::REG_PER_LO) && ctl_r[i].capture_mode)
          cap2_hl_r[i] <= cap2_r[i][15:8];
      end
    end
  end

  // ******************************************************************
  // Outputs
  // ******************************************************************
  // Pad drive follows output_enable; port direction still rules outside
  always_comb
  begin
    for (int i = 0; i < mft_pkg::NUM_TIMERS; i++)
      timer_output_oe_o[i] = ctl_r[i].output_enable;
  end

  assign timer_output_o = out_r;
  assign irq_o = irq_r;
  assign rdata_o = rdata_r;

endmodule

//--- rtl/mft_pkg.sv
// Constants, register map and field layout for the dual multifunction timer
package mft_pkg;

  // ******************************************************************
  // Geometry
  // ******************************************************************
  localparam int NUM_TIMERS = 2;
  localparam int PINS_PER_TIMER = 3;
  localparam int PIN_CAP1 = 0;
  localparam int PIN_CAP2 = 1;
  localparam int PIN_ECLK = 2;
  localparam int TIMER_SEL_BIT = 4;
  localparam int SHARED_SEL_BIT = 5;

  // ******************************************************************
  // Register offsets inside one timer (timer 0 at 0x00, timer 1 at 0x10)
  // ******************************************************************
  localparam logic [3:0] REG_CNT_LO = 4'h0;
  localparam logic [3:0] REG_CNT_HI = 4'h1;
  localparam logic [3:0] REG_CAP1_LO = 4'h2;
  localparam logic [3:0] REG_CAP1_HI = 4'h3;
  localparam logic [3:0] REG_CMP1_LO = 4'h4;
  localparam logic [3:0] REG_CMP1_HI = 4'h5;
  localparam logic [3:0] REG_PER_LO = 4'h6;
  localparam logic [3:0] REG_PER_HI = 4'h7;
  localparam logic [3:0] REG_CFG1_LO = 4'h8;
  localparam logic [3:0] REG_CFG1_HI = 4'h9;
  localparam logic [3:0] REG_CFG2_LO = 4'ha;
  localparam logic [3:0] REG_CFG2_HI = 4'hb;
  localparam logic [5:0] ADDR_CTRL = 6'h20;

  // ******************************************************************
  // Field positions
  // ******************************************************************
  // timer_config_1 low byte: flags [3:0], enables [7:4]
  localparam int FLAG_CMP1 = 0;
  localparam int FLAG_CAP1 = 1;
  localparam int FLAG_CAP2 = 2;
  localparam int FLAG_OVF = 3;
  localparam int IE_LSB = 4;
  // timer_config_2 low byte: edge selects and prescale_select
  localparam int EDGE1_LSB = 0;
  localparam int EDGE2_LSB = 2;
  localparam int PS_LSB = 4;
  localparam int EDGE_RISE_BIT = 0;
  localparam int EDGE_FALL_BIT = 1;
  // timer_config_2 high byte
  localparam int FORCE_HIGH_BIT = 0;
  localparam int FORCE_LOW_BIT = 1;
  localparam int TIE_BIT = 2;

  // ******************************************************************
  // Reset values and counts
  // ******************************************************************
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [14:0] PS_RESET = 15'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [14:0] PS_ONES = 15'h7fff;

  // timer_config_1 high byte
  typedef struct packed {
    logic timer_en;
    logic reset_on_cap1;
    logic ext_clk_fall;
    logic cap1_en;
    logic cap2_en;
    logic ext_clk_en;
    logic output_enable;
    logic capture_mode;
  } cfg1_ctl_t;

endpackage

//--- testbench/multifunction_timer_monitor.sv
// Port-level checker for the dual multifunction timer
`timescale 1ns/1ps
module multifunction_timer_monitor
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [5:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic [1:0] timer_output_o,
  input wire logic [1:0] timer_output_oe_o,
  input wire logic [1:0] irq_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // ******************************************************************
  // Bus steps of timer 0
  // ******************************************************************
  sequence cfg1_hi_wr;
    ce_i && wr_i && addr_i == 6'h09;
  endsequence
  sequence cfg2_hi_wr;
    ce_i && wr_i && addr_i == 6'h0b;
  endsequence
  sequence ie_off_wr;
    (ce_i && wr_i && addr_i == 6'h08 && wdata_i[7:4] == 4'h0) ##1 !(wr_i && addr_i == 6'h08);
  endsequence
  // ******************************************************************
  // Properties
  // ******************************************************************
  rdata_idle_a: assert property (ce_i && !rd_i |=> rdata_o == 8'h00)
    else $error("read data not idle");
  ctrl_read_zero_a: assert property (ce_i && rd_i && addr_i == 6'h20 |=> rdata_o == 8'h00)
    else $error("control register read not zero");
  oe_follow_a: assert property (cfg1_hi_wr |=> timer_output_oe_o[0] == $past(wdata_i[1]))
    else $error("output enable did not follow write");
  oe_follow_b_a: assert property (ce_i && wr_i && addr_i == 6'h19 |=> timer_output_oe_o[1] == $past(wdata_i[1]))
    else $error("second output enable did not follow write");
  oe_hold_a: assert property (!(wr_i && addr_i == 6'h09) |=> $stable(timer_output_oe_o[0]))
    else $error("output enable changed without write");
  force_high_a: assert property (cfg2_hi_wr and (wdata_i[0] && timer_output_oe_o[0]) |=> timer_output_o[0])
    else $error("forced high not seen");
  force_low_a: assert property (cfg2_hi_wr and (wdata_i[1:0] == 2'b10 && timer_output_oe_o[0]) |=> !timer_output_o[0])
    else $error("forced low not seen");
  irq_off_a: assert property (ie_off_wr |=> irq_o[0] == 1'b0)
    else $error("interrupt with all enables clear");
  reset_quiet_a: assert property ($fell(reset_i) |-> irq_o == 2'b00 && timer_output_o == 2'b00)
    else $error("outputs not quiet after reset");
endmodule

//--- testbench/timer_pin_model.sv
// Far-side pin model: capture source, quiet clock and spare pins
`timescale 1ns/1ps
module timer_pin_model
(
  input wire logic cap_req_i,
  output logic [1:0] capture_in_1_o,
  output logic [1:0] capture_in_2_o,
  output logic [1:0] ext_event_clock_o
);
  // Edges land mid-cycle, as from a source unrelated to the core clock
  assign #7 capture_in_1_o = {2{cap_req_i}};
  // Spare pins rest on their pull-downs; a broken tie then never captures
  assign capture_in_2_o = 2'b00;
  assign ext_event_clock_o = 2'b00;
endmodule

//--- testbench/multifunction_timer_tb.sv
// Self-checking bench for the dual multifunction timer
`timescale 1ns/1ps
module multifunction_timer_tb;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic cap_req = 1'b0;
  logic [5:0] addr_i = 6'h00;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rdata_o;
  logic [15:0] v;
  logic [1:0] out, oe, irq, cap1, cap2, eclk;
  int fail_count = 0;
  int n_compared = 0;
  int seed = 99352;
  int n, p, c, hi;
  always #12.5 core_clk_i = ~core_clk_i;
  multifunction_timer multifunction_timer_i (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .ce_i(1'b1), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .capture_in_1_i(cap1), .capture_in_2_i(cap2), .ext_event_clock_i(eclk), .rdata_o(rdata_o),
    .timer_output_o(out), .timer_output_oe_o(oe), .irq_o(irq));
  timer_pin_model timer_pin_model_i (.cap_req_i(cap_req), .capture_in_1_o(cap1),
    .capture_in_2_o(cap2), .ext_event_clock_o(eclk));
  // ******************************************************************
  // Bus tasks and comparison
  // ******************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  // Strobe drops at the taking edge, so a following call starts a cycle later
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  // Low byte first, so the high byte comes from the latch
  task automatic rd16(input logic [5:0] a, output logic [15:0] d);
    rd(a, d[7:0]);
    rd(a + 6'h01, d[15:8]);
  endtask
  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ******************************************************************
  // Scenarios
  // ******************************************************************
  initial
  begin
    repeat (3) @(posedge core_clk_i);
    reset_i <= 1'b0;
    for (int a = 0; a < 28; a++)
      if ((a & 15) < 12)
      begin
        rd(a[5:0], v[7:0]);
        check({8'h00, v[7:0]}, 16'h0000);
      end
    rd(6'h20, v[7:0]);
    rd(6'h3f, v[15:8]);
    check(v, 16'h0000);
    $display("reset values done");
    n = $random(seed);
    wr(6'h14, 8'(n));
    wr(6'h15, 8'(n >> 8));
    rd16(6'h14, v);
    check(v, 16'(n));
    // Counts of whole prescaler periods do not depend on its phase
    for (int k = 0; k < 4; k++)
    begin
      n = ((($random(seed) & 7) + 2) << k);
      wr(6'h0a, 8'(k << 4));
      wr(6'h20, 8'h01);
      wr(6'h09, 8'h80);
      repeat (n - 2) @(posedge core_clk_i);
      wr(6'h09, 8'h00);
      rd16(6'h00, v);
      check(v, 16'(n >> k));
    end
    $display("prescaler done");
    wr(6'h09, 8'h19);
    wr(6'h0a, 8'h05);
    wr(6'h0b, 8'h04);
    wr(6'h08, 8'h20);
    cap_req <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    check({15'h0000, irq[0]}, 16'h0001);
    rd16(6'h02, v);
    check(v, 16'(n >> 3));
    rd16(6'h06, v);
    check(v, 16'(n >> 3));
    wr(6'h08, 8'h20);
    repeat (2) @(posedge core_clk_i);
    #1 check({15'h0000, irq[0]}, 16'h0000);
    $display("capture done");
    // Leave capture mode first, else the period bytes are refused
    wr(6'h09, 8'h00);
    // Zero, full and random duty; high time counted over three periods
    for (int j = 0; j < 3; j++)
    begin
      p = ($random(seed) & 15) + 4;
      c = (j == 0) ? 0 : (j == 1) ? p : 1 + (($random(seed) & 255) % (p - 1));
      wr(6'h06, 8'(p));
      wr(6'h07, 8'h00);
      wr(6'h04, 8'(c));
      wr(6'h05, 8'h00);
      wr(6'h0a, 8'h00);
      wr(6'h09, 8'h82);
      wr(6'h20, 8'h01);
      repeat (2 * p) @(posedge core_clk_i);
      hi = 0;
      repeat (3 * p)
      begin
        @(posedge core_clk_i);
        #1 hi += out[0];
      end
      check(16'(hi), 16'(3 * c));
    end
    $display("pwm done");
    wr(6'h09, 8'h02);
    wr(6'h0b, 8'h01);
    #1 check({15'h0000, out[0]}, 16'h0001);
    wr(6'h0b, 8'h02);
    #1 check({15'h0000, out[0]}, 16'h0000);
    wr(6'h09, 8'h80);
    #1 check({15'h0000, oe[0]}, 16'h0000);
    // Second timer: its enable follows, its output and interrupt stay idle
    wr(6'h19, 8'h02);
    #1 check({13'h0000, oe[1], out[1], irq[1]}, 16'h0004);
    // Enables on, flags kept: the PWM reset flag raises the interrupt
    wr(6'h08, 8'hff);
    repeat (2) @(posedge core_clk_i);
    #1 check({15'h0000, irq[0]}, 16'h0001);
    wr(6'h08, 8'h00);
    repeat (2) @(posedge core_clk_i);
    #1 check({15'h0000, irq[0]}, 16'h0000);
    $display("force done");
    final_report();
  end
  // Bounded watchdog: a hang counts as a mismatch
  initial
  begin
    repeat (60000) @(posedge core_clk_i);
    fail_count++;
    final_report();
  end
endmodule
bind multifunction_timer multifunction_timer_monitor multifunction_timer_monitor_i (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .ce_i(ce_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .timer_output_o(timer_output_o), .timer_output_oe_o(timer_output_oe_o), .irq_o(irq_o));
